// ==== src/rsbc_top.sv ====
//
// Behaviour
// - Latch boot and memory straps during every reset, oscillator strap on block reset only; keep afterwards.
// - Shared pins return to memory and GPIO use automatically.
// - Boot select from address pins 13..11, MSB 13.
// - Decode eight boot sources from boot select.
// - Undriven boot pins pull to 000, NAND.
// - Memory config from pins 10..8; bit2 width.
// - Oscillator range from general pin 81, default 0.
// - Mode bands fixed; no change while oscillator runs.
// - All PLLs bypassed and disabled after reset.
// - Unmarked modules start disabled after reset.
// - Timers, system, core, emulation, RTC enabled after every reset for every boot code.
// - DMA modules on for 000, 001, 100, 110.
// - Async memory module on for 000, 001.
// - Each peripheral boot enables its own module.
// - Start in ROM 0x8000 unless external boot.
// - Strap only sets default pin mux; software overrides.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps

module rsbc_top (
	// Clock, block reset and enable.
	input  wire logic                clock_i,
	input  wire logic                nrst_i,
	input  wire logic                ce_i,
	// Device reset requests.
	input  wire logic                dev_rst_n_i,
	input  wire logic                max_rst_i,
	// Shared address pins 13..8.
	input  wire logic [5:0]          ext_mem_addr_pin_i,
	output logic      [5:0]          ext_mem_addr_pin_o,
	output logic      [5:0]          ext_mem_addr_pin_oe_o,
	// Shared general pin 81.
	input  wire logic                general_io_81_i,
	output logic                     general_io_81_o,
	output logic                     general_io_81_oe_o,
	output logic                     strap_pulldown_en_o,
	// Memory controller and GPIO drive for the shared pins.
	input  wire logic [5:0]          mem_addr_i,
	input  wire logic                mem_addr_oe_i,
	input  wire logic                gpio81_out_i,
	input  wire logic                gpio81_oe_i,
	// Latched configuration.
	output logic      [2:0]          boot_select_o,
	output logic      [2:0]          ext_mem_pin_config_o,
	output logic                     ext_mem_16bit_o,
	output logic                     osc_range_select_o,
	output logic                     boot_from_rom_o,
	output logic      [31:0]         boot_vector_o,
	output logic                     straps_valid_o,
	// Clocking and module power state.
	output logic      [1:0]          pll_enable_o,
	output logic      [1:0]          pll_bypass_o,
	output logic      [51:0]         module_enable_o,
	// Register port.
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_we_i,
	input  wire logic                reg_re_i,
	output logic      [31:0]         reg_rdata_o
);

	// ****************************************************************
	// Decoding functions
	// ****************************************************************

	// Default power state of every module for a given boot source.
	function automatic logic [51:0] rsbc_mod_default(input logic [2:0] b);
		logic [51:0] m;
		m = '0;
		m[rsbc_pkg::MOD_TIMER0] = 1'b1;
		m[rsbc_pkg::MOD_TIMER2] = 1'b1;
		m[rsbc_pkg::MOD_SYSTEM] = 1'b1;
		m[rsbc_pkg::MOD_CORE]   = 1'b1;
		m[rsbc_pkg::MOD_RSVD34] = 1'b1;
		m[rsbc_pkg::MOD_EMUL]   = 1'b1;
		m[rsbc_pkg::MOD_RTC]    = 1'b1;
		case (b)
			rsbc_pkg::BOOT_NAND,
			rsbc_pkg::BOOT_EXTM:
			begin
				m[rsbc_pkg::MOD_DMA_CC]  = 1'b1;
				m[rsbc_pkg::MOD_DMA_TC0] = 1'b1;
				m[rsbc_pkg::MOD_EXTM]    = 1'b1;
			end
			rsbc_pkg::BOOT_MMC:  m[rsbc_pkg::MOD_MMC0]  = 1'b1;
			rsbc_pkg::BOOT_UART: m[rsbc_pkg::MOD_UART0] = 1'b1;
			rsbc_pkg::BOOT_USB:
			begin
				m[rsbc_pkg::MOD_DMA_CC]  = 1'b1;
				m[rsbc_pkg::MOD_DMA_TC0] = 1'b1;
				m[rsbc_pkg::MOD_USB]     = 1'b1;
			end
			rsbc_pkg::BOOT_SPI:  m[rsbc_pkg::MOD_SPI0]  = 1'b1;
			rsbc_pkg::BOOT_ETH:
			begin
				m[rsbc_pkg::MOD_DMA_CC]  = 1'b1;
				m[rsbc_pkg::MOD_DMA_TC0] = 1'b1;
				m[rsbc_pkg::MOD_ETH]     = 1'b1;
			end
			rsbc_pkg::BOOT_HOST: m[rsbc_pkg::MOD_HOST]  = 1'b1;
			default:             m = m;
		endcase
		return m;
	endfunction : rsbc_mod_default

	// Pins 13..8 carry address bits only for codes whose two low bits are not both zero.
	function automatic logic rsbc_addr_hi_on(input logic [2:0] cfg);
		return (cfg[1:0] != 2'h0);
	endfunction : rsbc_addr_hi_on

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [7:0] sync_s;
	logic       dev_rst_s;
	logic       in_reset_s;

	rsbc_sync #(
		.W       (rsbc_pkg::SYNC_W)
	) u_sync (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.ce_i    (ce_i),
		.async_i ({dev_rst_n_i, general_io_81_i, ext_mem_addr_pin_i}),
		.sync_o  (sync_s)
	);

	// The filtered reset pin lags by the same three stages as the straps,
	// so the last sample taken before release matches the pins then.
	assign dev_rst_s  = ~sync_s[rsbc_pkg::SYNC_RSTN];
	assign in_reset_s = dev_rst_s | max_rst_i;

	// ****************************************************************
	// Capture sequencer and strap latches
	// ****************************************************************
	rsbc_pkg::rsbc_state_e state_q, state_d;
	logic [2:0] boot_q, boot_d;
	logic [2:0] memcfg_q, memcfg_d;
	logic       osc_q, osc_d;
	logic       osc_lock_q, osc_lock_d;
	logic       valid_q, valid_d;

	// The oscillator strap is taken only in the first capture after a block reset;
	// warm and max resets leave the running band untouched.
	always_comb
	begin
		state_d    = state_q;
		boot_d     = boot_q;
		memcfg_d   = memcfg_q;
		osc_d      = osc_q;
		osc_lock_d = osc_lock_q;
		valid_d    = valid_q;
		case (state_q)
			rsbc_pkg::RSBC_HOLD:
			begin
				// Follow the pins for as long as reset lasts.
				boot_d   = sync_s[rsbc_pkg::BOOT_LSB +: 3];
				memcfg_d = sync_s[rsbc_pkg::MEMCFG_LSB +: 3];
				if (!osc_lock_q)
					osc_d = sync_s[rsbc_pkg::SYNC_OSC];
				valid_d = 1'b0;
				if (!in_reset_s)
				begin
					osc_lock_d = 1'b1;
					valid_d    = 1'b1;
					state_d    = rsbc_pkg::RSBC_RELEASE;
				end
			end
			rsbc_pkg::RSBC_RELEASE:
			begin
				state_d = in_reset_s ? rsbc_pkg::RSBC_HOLD
					: rsbc_pkg::RSBC_RUN;
			end
			rsbc_pkg::RSBC_RUN:
			begin
				if (in_reset_s)
					state_d = rsbc_pkg::RSBC_HOLD;
			end
			default: state_d = rsbc_pkg::RSBC_HOLD;
		endcase
	end

	// Pull defaults stand in the latches until the first capture.
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q    <= rsbc_pkg::RSBC_HOLD;
			boot_q     <= rsbc_pkg::BOOT_RST;
			memcfg_q   <= rsbc_pkg::MEMCFG_RST;
			osc_q      <= rsbc_pkg::OSC_RST;
			osc_lock_q <= 1'b0;
			valid_q    <= 1'b0;
		end
		else if (ce_i)
		begin
			state_q    <= state_d;
			boot_q     <= boot_d;
			memcfg_q   <= memcfg_d;
			osc_q      <= osc_d;
			osc_lock_q <= osc_lock_d;
			valid_q    <= valid_d;
		end
	end

	// ****************************************************************
	// Software-visible configuration
	// ****************************************************************
	logic [2:0]  pincfg_q, pincfg_d;
	logic [1:0]  pll_en_q, pll_en_d;
	logic [1:0]  pll_byp_q, pll_byp_d;
	logic [51:0] mod_q, mod_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] status_w;
	logic [31:0] vec_w;

	assign vec_w = (boot_q == rsbc_pkg::BOOT_EXTM) ? rsbc_pkg::EXT_BOOT_ADDR
		: rsbc_pkg::ROM_BOOT_ADDR;

	always_comb
	begin
		status_w = '0;
		status_w[2:0] = boot_q;
		status_w[rsbc_pkg::ST_MEMCFG +: 3] = memcfg_q;
		status_w[rsbc_pkg::ST_OSC]   = osc_q;
		status_w[rsbc_pkg::ST_VALID] = valid_q;
	end

	// While reset is held the pin mux and modules track their strap-derived defaults, the PLLs their fixed one;
	// writes in that time are dropped because they would be overwritten.
	always_comb
	begin
		pincfg_d  = pincfg_q;
		pll_en_d  = pll_en_q;
		pll_byp_d = pll_byp_q;
		mod_d     = mod_q;
		if (state_q == rsbc_pkg::RSBC_HOLD)
		begin
			pincfg_d  = memcfg_d;
			pll_en_d  = '0;
			pll_byp_d = '1;
			mod_d     = rsbc_mod_default(boot_d);
		end
		else if (reg_we_i)
		begin
			case (reg_addr_i)
				rsbc_pkg::REG_PINCFG: pincfg_d = reg_wdata_i[2:0];
				rsbc_pkg::REG_PLL:
				begin
					pll_en_d  = reg_wdata_i[1:0];
					pll_byp_d = reg_wdata_i[rsbc_pkg::PLL_BYP_LSB +: 2];
				end
				rsbc_pkg::REG_MODLO: mod_d[31:0]  = reg_wdata_i;
				rsbc_pkg::REG_MODHI: mod_d[51:32] = reg_wdata_i[19:0];
				default:             mod_d = mod_q;
			endcase
		end
	end

	// Read data stand for one cycle after the strobe, zero otherwise.
	always_comb
	begin
		rdata_d = '0;
		if (reg_re_i)
		begin
			case (reg_addr_i)
				rsbc_pkg::REG_STATUS:  rdata_d = status_w;
				rsbc_pkg::REG_PINCFG:  rdata_d = {29'h0, pincfg_q};
				rsbc_pkg::REG_PLL:     rdata_d = {26'h0, pll_byp_q, 2'h0,
					pll_en_q};
				rsbc_pkg::REG_MODLO:   rdata_d = mod_q[31:0];
				rsbc_pkg::REG_MODHI:   rdata_d = {12'h0, mod_q[51:32]};
				rsbc_pkg::REG_BOOTVEC: rdata_d = vec_w;
				default:               rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pincfg_q  <= rsbc_pkg::MEMCFG_RST;
			pll_en_q  <= '0;
			pll_byp_q <= '1;
			mod_q     <= rsbc_mod_default(rsbc_pkg::BOOT_RST);
			rdata_q   <= '0;
		end
		else if (ce_i)
		begin
			pincfg_q  <= pincfg_d;
			pll_en_q  <= pll_en_d;
			pll_byp_q <= pll_byp_d;
			mod_q     <= mod_d;
			rdata_q   <= rdata_d;
		end
	end

	// ****************************************************************
	// Shared pin drive
	// ****************************************************************
	logic [5:0] pin_q, pin_d;
	logic [5:0] pin_oe_q, pin_oe_d;
	logic       g81_q, g81_d;
	logic       g81_oe_q, g81_oe_d;
	logic       run_w;

	assign run_w = (state_q == rsbc_pkg::RSBC_RUN);

	// Pins stay released until the capture is frozen, so the pulls and the
	// board alone set their level; the memory drive returns unasked.
	always_comb
	begin
		pin_d    = mem_addr_i;
		pin_oe_d = {6{run_w & mem_addr_oe_i & rsbc_addr_hi_on(pincfg_q)}};
		g81_d    = gpio81_out_i;
		g81_oe_d = run_w & gpio81_oe_i;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_q    <= '0;
			pin_oe_q <= '0;
			g81_q    <= 1'b0;
			g81_oe_q <= 1'b0;
		end
		else if (ce_i)
		begin
			pin_q    <= pin_d;
			pin_oe_q <= pin_oe_d;
			g81_q    <= g81_d;
			g81_oe_q <= g81_oe_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign ext_mem_addr_pin_o    = pin_q;
	assign ext_mem_addr_pin_oe_o = pin_oe_q;
	assign general_io_81_o       = g81_q;
	assign general_io_81_oe_o    = g81_oe_q;
	assign strap_pulldown_en_o   = (state_q == rsbc_pkg::RSBC_HOLD);
	assign boot_select_o         = boot_q;
	assign ext_mem_pin_config_o  = pincfg_q;
	assign ext_mem_16bit_o       = memcfg_q[rsbc_pkg::MEMCFG_WIDE];
	assign osc_range_select_o    = osc_q;
	assign boot_from_rom_o       = (boot_q != rsbc_pkg::BOOT_EXTM);
	assign boot_vector_o         = vec_w;
	assign straps_valid_o        = valid_q;
	assign pll_enable_o          = pll_en_q;
	assign pll_bypass_o          = pll_byp_q;
	assign module_enable_o       = mod_q;
	assign reg_rdata_o           = rdata_q;

endmodule : rsbc_top

// ==== src/rsbc_pkg.sv ====
package rsbc_pkg;

	// ****************************************************************
	// Strap field layout and pull defaults
	// ****************************************************************
	localparam int unsigned BOOT_W      = 3;
	localparam int unsigned MEMCFG_W    = 3;
	localparam int unsigned STRAP_PINS  = 6;
	localparam int unsigned SYNC_W      = 8;
	// Positions inside the shared address pin group (pin 8 is bit 0).
	localparam int unsigned BOOT_LSB    = 3;
	localparam int unsigned MEMCFG_LSB  = 0;
	localparam int unsigned MEMCFG_WIDE = 2;
	// Positions inside the synchroniser word.
	localparam int unsigned SYNC_OSC    = 6;
	localparam int unsigned SYNC_RSTN   = 7;
	localparam logic [2:0]  BOOT_RST    = 3'h0;
	localparam logic [2:0]  MEMCFG_RST  = 3'h0;
	localparam logic        OSC_RST     = 1'b0;

	// ****************************************************************
	// Boot selection codes
	// ****************************************************************
	localparam logic [2:0] BOOT_NAND = 3'h0;
	localparam logic [2:0] BOOT_EXTM = 3'h1;
	localparam logic [2:0] BOOT_MMC  = 3'h2;
	localparam logic [2:0] BOOT_UART = 3'h3;
	localparam logic [2:0] BOOT_USB  = 3'h4;
	localparam logic [2:0] BOOT_SPI  = 3'h5;
	localparam logic [2:0] BOOT_ETH  = 3'h6;
	localparam logic [2:0] BOOT_HOST = 3'h7;

	// Execution start addresses.
	localparam logic [31:0] ROM_BOOT_ADDR = 32'h0000_8000;
	localparam logic [31:0] EXT_BOOT_ADDR = 32'h0000_0000;

	// ****************************************************************
	// Module power slots
	// ****************************************************************
	localparam int unsigned MOD_N       = 52;
	localparam int unsigned MOD_DMA_CC  = 0;
	localparam int unsigned MOD_DMA_TC0 = 1;
	localparam int unsigned MOD_USB     = 9;
	localparam int unsigned MOD_EXTM    = 14;
	localparam int unsigned MOD_MMC0    = 15;
	localparam int unsigned MOD_UART0   = 19;
	localparam int unsigned MOD_HOST    = 21;
	localparam int unsigned MOD_SPI0    = 22;
	localparam int unsigned MOD_TIMER0  = 27;
	localparam int unsigned MOD_TIMER2  = 29;
	localparam int unsigned MOD_SYSTEM  = 30;
	localparam int unsigned MOD_CORE    = 31;
	localparam int unsigned MOD_RSVD34  = 34;
	localparam int unsigned MOD_EMUL    = 35;
	localparam int unsigned MOD_ETH     = 40;
	localparam int unsigned MOD_RTC     = 41;

	// ****************************************************************
	// Oscillator bands in MHz
	// ****************************************************************
	localparam int unsigned OSC1_MIN_MHZ = 15;
	localparam int unsigned OSC1_MAX_MHZ = 35;
	localparam int unsigned OSC2_MIN_MHZ = 30;
	localparam int unsigned OSC2_MAX_MHZ = 40;

	// ****************************************************************
	// PLLs and register map
	// ****************************************************************
	localparam int unsigned PLL_N       = 2;
	localparam int unsigned PLL_BYP_LSB = 4;
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  REG_STATUS  = 8'h00;
	localparam logic [7:0]  REG_PINCFG  = 8'h04;
	localparam logic [7:0]  REG_PLL     = 8'h08;
	localparam logic [7:0]  REG_MODLO   = 8'h0c;
	localparam logic [7:0]  REG_MODHI   = 8'h10;
	localparam logic [7:0]  REG_BOOTVEC = 8'h14;
	localparam int unsigned ST_MEMCFG   = 4;
	localparam int unsigned ST_OSC      = 8;
	localparam int unsigned ST_VALID    = 12;

	typedef enum logic [1:0] {
		RSBC_HOLD    = 2'b00,
		RSBC_RELEASE = 2'b01,
		RSBC_RUN     = 2'b11
	} rsbc_state_e;

endpackage : rsbc_pkg

// ==== src/rsbc_sync.sv ====
`timescale 1ns/1ps

module rsbc_sync #(
	parameter int unsigned W = 8
) (
	// Clock, reset and enable.
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	input  wire logic         ce_i,
	// Asynchronous inputs and their filtered copies.
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ****************************************************************
	// Three-stage synchroniser per bit
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic s1_q, s2_q, s3_q, out_q;
			logic out_d;

			// A change counts only once stages two and three agree.
			always_comb
			begin
				out_d = (s2_q == s3_q) ? s3_q : out_q;
			end

			// Stage one feeds stage two only, never the filter.
			always_ff @(posedge clock_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					out_q <= 1'b0;
				end
				else if (ce_i)
				begin
					s1_q  <= async_i[g];
					s2_q  <= s1_q;
					s3_q  <= s2_q;
					out_q <= out_d;
				end
			end

			assign sync_o[g] = out_q;
		end
	endgenerate

endmodule : rsbc_sync

// ==== sim/rsbc_board.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Board strapping on the shared pins
// ****************************************************************
module rsbc_board (
	// Clock for the floating pattern.
	input  wire logic       clock_i,
	// Board strap drive, bit 6 is pin 81, bits 5..0 pins 13..8.
	input  wire logic       drive_i,
	input  wire logic [6:0] strap_i,
	// Device drive and internal pull state.
	input  wire logic [6:0] dev_out_i,
	input  wire logic [6:0] dev_oe_i,
	input  wire logic       pull_i,
	// Resolved pin levels.
	output logic      [6:0] level_o
);
	logic float_q = 1'b0;

	// An unpulled, undriven pin toggles so a stale level is never trusted.
	always_ff @(posedge clock_i)
	begin
		float_q <= ~float_q;
	end

	// The device wins, then the board strap, then the internal pull.
	always_comb
	begin
		for (int i = 0; i < 7; i++)
		begin
			if (dev_oe_i[i])
				level_o[i] = dev_out_i[i];
			else if (drive_i)
				level_o[i] = strap_i[i];
			else if (pull_i)
				level_o[i] = 1'b0;
			else
				level_o[i] = float_q;
		end
	end
endmodule : rsbc_board

// ==== sim/rsbc_top_checker.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the strap loader
// ****************************************************************
module rsbc_top_checker (
	// Clock and reset.
	input wire logic        clock_i,
	input wire logic        nrst_i,
	// Drive requests and register port.
	input wire logic        mem_addr_oe_i,
	input wire logic        gpio81_out_i,
	input wire logic        gpio81_oe_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_re_i,
	// Pin control.
	input wire logic [5:0]  ext_mem_addr_pin_oe_o,
	input wire logic        general_io_81_o,
	input wire logic        general_io_81_oe_o,
	input wire logic        strap_pulldown_en_o,
	// Latched configuration and power state.
	input wire logic [2:0]  boot_select_o,
	input wire logic [2:0]  ext_mem_pin_config_o,
	input wire logic        ext_mem_16bit_o,
	input wire logic        osc_range_select_o,
	input wire logic        boot_from_rom_o,
	input wire logic [31:0] boot_vector_o,
	input wire logic        straps_valid_o,
	input wire logic [1:0]  pll_enable_o,
	input wire logic [1:0]  pll_bypass_o,
	input wire logic [51:0] module_enable_o,
	input wire logic [31:0] reg_rdata_o
);
	logic low_cfg;

	// Address drive needs a non-zero low pin-mux field.
	assign low_cfg = |ext_mem_pin_config_o[1:0];

	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// Two cycles of capture, and four cycles after release.
	sequence s_hold;
		strap_pulldown_en_o ##1 strap_pulldown_en_o;
	endsequence
	sequence s_run;
		straps_valid_o [*4];
	endsequence

	chk_pll_default: assert property (
		s_hold |-> pll_bypass_o == 2'b11 && pll_enable_o == 2'b00)
		else $error("pll not bypassed during capture");
	chk_pins_quiet: assert property (
		s_hold |-> ext_mem_addr_pin_oe_o == 6'h00 && !general_io_81_oe_o)
		else $error("shared pin driven during capture");
	chk_always_on: assert property (
		$rose(straps_valid_o) |=> module_enable_o[41]
		&& module_enable_o[35:34] == 2'b11
		&& module_enable_o[31:29] == 3'b111 && module_enable_o[27])
		else $error("fixed module not enabled");
	chk_dma_boot: assert property (
		$rose(straps_valid_o) |=> module_enable_o[1:0] ==
		((boot_select_o inside {3'h0, 3'h1, 3'h4, 3'h6}) ? 2'b11 : 2'b00))
		else $error("dma enables wrong for boot code");
	chk_boot_vector: assert property (
		straps_valid_o |-> boot_from_rom_o == (boot_select_o != 3'h1)
		&& boot_vector_o == (boot_select_o == 3'h1 ?
		rsbc_pkg::EXT_BOOT_ADDR : rsbc_pkg::ROM_BOOT_ADDR))
		else $error("boot vector wrong");
	chk_strap_frozen: assert property (
		straps_valid_o ##1 straps_valid_o |-> $stable(boot_select_o)
		&& $stable(osc_range_select_o) && $stable(ext_mem_16bit_o))
		else $error("strap value moved after release");
	chk_gio_return: assert property (
		s_run |-> general_io_81_oe_o == $past(gpio81_oe_i)
		&& general_io_81_o == $past(gpio81_out_i))
		else $error("pin 81 not returned to normal use");
	chk_addr_return: assert property (
		s_run |-> ext_mem_addr_pin_oe_o ==
		(($past(mem_addr_oe_i) && $past(low_cfg)) ? 6'h3f : 6'h00))
		else $error("address pin drive wrong");
	chk_status_read: assert property (
		$past(reg_re_i) && $past(reg_addr_i) == 8'h00 && straps_valid_o
		&& $past(straps_valid_o) |-> reg_rdata_o[2:0] == boot_select_o
		&& reg_rdata_o[8] == osc_range_select_o)
		else $error("status read disagrees with latch");
endmodule : rsbc_top_checker

bind rsbc_top rsbc_top_checker u_chk (
	.clock_i(clock_i), .nrst_i(nrst_i), .mem_addr_oe_i(mem_addr_oe_i),
	.gpio81_out_i(gpio81_out_i), .gpio81_oe_i(gpio81_oe_i),
	.reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i),
	.ext_mem_addr_pin_oe_o(ext_mem_addr_pin_oe_o),
	.general_io_81_o(general_io_81_o),
	.general_io_81_oe_o(general_io_81_oe_o),
	.strap_pulldown_en_o(strap_pulldown_en_o),
	.boot_select_o(boot_select_o),
	.ext_mem_pin_config_o(ext_mem_pin_config_o),
	.ext_mem_16bit_o(ext_mem_16bit_o),
	.osc_range_select_o(osc_range_select_o),
	.boot_from_rom_o(boot_from_rom_o), .boot_vector_o(boot_vector_o),
	.straps_valid_o(straps_valid_o), .pll_enable_o(pll_enable_o),
	.pll_bypass_o(pll_bypass_o), .module_enable_o(module_enable_o),
	.reg_rdata_o(reg_rdata_o));

// ==== sim/reset_strap_boot_config_tb.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Strap loader testbench
// ****************************************************************
module reset_strap_boot_config_tb;
	logic        clock_i = 1'b0;
	logic        nrst_i, ce_i, dev_rst_n_i, max_rst_i, drive;
	logic [6:0]  strap, level;
	logic [5:0]  mem_addr_i, pin_o, pin_oe;
	logic        mem_addr_oe_i, gpio81_out_i, gpio81_oe_i, g81_o, g81_oe;
	logic        pull, w16, from_rom, valid, osc;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, rdata, vec, d;
	logic        reg_we_i, reg_re_i;
	logic [2:0]  boot, mcfg;
	logic [1:0]  pll_en, pll_byp;
	logic [51:0] mods;
	int          n_fail = 0;
	int          n_checks = 0;

	rsbc_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.dev_rst_n_i(dev_rst_n_i), .max_rst_i(max_rst_i),
		.ext_mem_addr_pin_i(level[5:0]), .ext_mem_addr_pin_o(pin_o),
		.ext_mem_addr_pin_oe_o(pin_oe), .general_io_81_i(level[6]),
		.general_io_81_o(g81_o), .general_io_81_oe_o(g81_oe),
		.strap_pulldown_en_o(pull), .mem_addr_i(mem_addr_i),
		.mem_addr_oe_i(mem_addr_oe_i), .gpio81_out_i(gpio81_out_i),
		.gpio81_oe_i(gpio81_oe_i), .boot_select_o(boot),
		.ext_mem_pin_config_o(mcfg), .ext_mem_16bit_o(w16),
		.osc_range_select_o(osc), .boot_from_rom_o(from_rom),
		.boot_vector_o(vec), .straps_valid_o(valid),
		.pll_enable_o(pll_en), .pll_bypass_o(pll_byp),
		.module_enable_o(mods), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i), .reg_rdata_o(rdata));

	rsbc_board u_board (.clock_i(clock_i), .drive_i(drive),
		.strap_i(strap), .dev_out_i({g81_o, pin_o}),
		.dev_oe_i({g81_oe, pin_oe}), .pull_i(pull), .level_o(level));

	// 10 MHz clock.
	initial
	begin
		forever #50 clock_i = ~clock_i;
	end

	// Enables expected for a boot code, built independently of the design.
	function automatic logic [51:0] exp_mods(input logic [2:0] b);
		logic [51:0] m;
		m = 52'h0020ce8000000;
		if (b inside {3'h0, 3'h1, 3'h4, 3'h6})
			m[1:0] = 2'b11;
		if (b <= 3'h1)
			m[14] = 1'b1;
		case (b)
			3'h2: m[15] = 1'b1;
			3'h3: m[19] = 1'b1;
			3'h4: m[9] = 1'b1;
			3'h5: m[22] = 1'b1;
			3'h6: m[40] = 1'b1;
			3'h7: m[21] = 1'b1;
			default: ;
		endcase
		return m;
	endfunction : exp_mods

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [51:0] got, input logic [51:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_we_i    <= 1'b1;
		@(posedge clock_i);
		reg_we_i <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe.
	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clock_i);
		reg_re_i <= 1'b0;
		#1 v = rdata;
	endtask : reg_read

	task automatic wait_valid();
		for (int i = 0; i < 40 && valid !== 1'b1; i++)
			@(posedge clock_i);
		chk(valid, 1'b1);
	endtask : wait_valid

	// A wrong strap first, the wanted one later, to prove tracking.
	task automatic dev_reset(input logic [2:0] b, input logic [2:0] m,
		input logic mx);
		@(posedge clock_i);
		drive <= 1'b1;
		strap <= {1'b1, ~b, ~m};
		if (mx)
			max_rst_i <= 1'b1;
		else
			dev_rst_n_i <= 1'b0;
		// The filtered pin needs four edges, valid drops two edges later.
		repeat (6) @(posedge clock_i);
		#1 chk({valid, pull}, 2'b01);
		strap <= {1'b1, b, m};
		reg_write(rsbc_pkg::REG_PINCFG, 32'h7);
		repeat (8) @(posedge clock_i);
		dev_rst_n_i <= 1'b1;
		max_rst_i   <= 1'b0;
		wait_valid();
	endtask : dev_reset

	task automatic check_boot(input logic [2:0] b, input logic [2:0] m,
		input logic o);
		repeat (4) @(posedge clock_i);
		#1 chk(boot, b);
		chk({w16, mcfg}, {m[2], m});
		chk(osc, o);
		chk(mods, exp_mods(b));
		chk(vec, b == 3'h1 ? 32'h0 : 32'h8000);
		chk(from_rom, b != 3'h1);
		chk({g81_oe, level[6]}, 2'b11);
		chk({pll_en, pll_byp}, 4'h3);
		chk(pin_oe, |m[1:0] ? 6'h3f : 6'h00);
		chk(level[5:0] & pin_oe, mem_addr_i & pin_oe);
		reg_read(rsbc_pkg::REG_STATUS, d);
		chk(d, {19'h0, 1'b1, 3'h0, o, 1'b0, m, 1'b0, b});
	endtask : check_boot

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		nrst_i = 1'b0;
		ce_i = 1'b1;
		dev_rst_n_i = 1'b1;
		max_rst_i = 1'b0;
		drive = 1'b0;
		strap = 7'h00;
		mem_addr_i = 6'h2a;
		mem_addr_oe_i = 1'b1;
		gpio81_out_i = 1'b1;
		gpio81_oe_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		wait_valid();
		check_boot(3'h0, 3'h0, 1'b0);
		// Every boot code, last one through the max reset.
		for (int c = 0; c < 8; c++)
		begin
			reg_write(rsbc_pkg::REG_PLL, 32'h3);
			reg_write(rsbc_pkg::REG_MODLO, 32'h0);
			#1 chk({pll_en, pll_byp, mods[31:0]}, 36'hc_0000_0000);
			dev_reset(c[2:0], ~c[2:0], c == 7);
			check_boot(c[2:0], ~c[2:0], 1'b0);
		end
		// Software overrides the pin-mux default but not the strap copy.
		reg_write(rsbc_pkg::REG_PINCFG, 32'h5);
		@(posedge clock_i);
		#1 chk(mcfg, 3'h5);
		reg_read(rsbc_pkg::REG_STATUS, d);
		chk(d[6:4], 3'h0);
		reg_read(8'h3c, d);
		chk(d, 32'h0);
		// A fresh block reset takes the oscillator strap again.
		@(posedge clock_i);
		nrst_i <= 1'b0;
		strap <= {1'b1, 3'h2, 3'h3};
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		wait_valid();
		check_boot(3'h2, 3'h3, 1'b1);
		// A low clock enable freezes the block, so a write must not land.
		@(posedge clock_i);
		ce_i <= 1'b0;
		reg_write(rsbc_pkg::REG_PINCFG, 32'h6);
		@(posedge clock_i);
		#1 chk(mcfg, 3'h3);
		ce_i <= 1'b1;
		tally_and_finish();
	end

	// Hang guard, well beyond the few hundred cycles the tests need.
	initial
	begin
		repeat (5000) @(posedge clock_i);
		n_fail++;
		tally_and_finish();
	end
endmodule : reset_strap_boot_config_tb
